// ### fus_pkg.sv
// package of constants and types for the flash unit status/reset sequencer
package fus_pkg;
    localparam logic [7:0] OP_READ_A = 8'h30;
    localparam logic [7:0] OP_READ_B = 8'h31;
    localparam logic [7:0] OP_READ_C = 8'h32;
    localparam logic [7:0] OP_READ_D = 8'h35;
    localparam logic [7:0] OP_LEGACY_STATUS = 8'h70;
    localparam logic [7:0] OP_ERASE_CONFIRM = 8'hD0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] OPCODE_RESET = 8'h00;
    localparam int BIT_READY = 6;
    localparam int BIT_ARRAY_READY = 5;
    // status kind requested by the target
    localparam logic [1:0] KIND_UNIT = 2'h0;
    localparam logic [1:0] KIND_LEGACY = 2'h1;
    localparam logic [1:0] KIND_MPL_COMP = 2'h2;
    localparam logic [1:0] KIND_MPL_ADDR = 2'h3;
    // interrupt status bit positions
    localparam int IRQ_RESET_DONE = 0;
    localparam int IRQ_ERASE_START = 1;
    localparam int IRQ_STATUS_DONE = 2;
    localparam int IRQ_WIDTH = 3;
    // register offsets of the small control port
    localparam logic [3:0] REG_IRQ_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ_MASK = 4'h4;
    localparam logic [3:0] REG_UNIT_STATE = 4'h8;
    typedef enum logic [3:0] {
        FUS_IDLE = 4'b0000,
        FUS_IDLE_RD = 4'b0001,
        FUS_ST_EXEC = 4'b0010,
        FUS_ST_UNIT = 4'b0011,
        FUS_ST_LEGACY = 4'b0100,
        FUS_ST_COMP = 4'b0101,
        FUS_ST_ADDR = 4'b0110,
        FUS_ST_VALUE = 4'b0111,
        FUS_ST_OFF = 4'b1000,
        FUS_RST_RUN = 4'b1001,
        FUS_RST_DONE = 4'b1010,
        FUS_BE_CONFIRM = 4'b1011,
        FUS_BE_WAIT = 4'b1100
    } fus_state_e;
endpackage : fus_pkg

// ### fus_status_compose.sv
// status byte composer for the flash unit sequencer
`timescale 1ns/1ps
module fus_status_compose #(
    parameter int PLANES = 4
) (
    input wire logic [7:0] unit_status_byte_i,
    input wire logic [PLANES*2-1:0] plane_fail_flags_i,
    input wire logic [$clog2(PLANES)-1:0] selected_plane_index_i,
    input wire logic [1:0] kind_i,
    output logic [7:0] status_o
);
    import fus_pkg::*;
    logic [1:0] fail_or;
    logic [1:0] fail_sel;
    // or-reduce per fail bit over all planes, and pick one plane
    always_comb begin
        fail_or = 2'h0;
        for (int p = 0; p < PLANES; p++) begin
            fail_or = fail_or | plane_fail_flags_i[p*2 +: 2];
        end
        fail_sel = plane_fail_flags_i[selected_plane_index_i*2 +: 2];
        unique case (kind_i)
            KIND_MPL_COMP: status_o = {unit_status_byte_i[7:2], fail_or};
            KIND_MPL_ADDR: status_o = {unit_status_byte_i[7:2], fail_sel};
            default: status_o = unit_status_byte_i;
        endcase
    end
endmodule : fus_status_compose

// ### fus_unit_fsm.sv
// per-unit status, reset and erase-confirm sequencer of a flash die
`timescale 1ns/1ps
module fus_unit_fsm #(
    parameter int PLANES = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic reset_req_i,
    input wire logic reset_finished_i,
    input wire logic status_req_i,
    input wire logic [1:0] status_kind_i,
    input wire logic status_done_i,
    input wire logic erase_confirm_i,
    input wire logic erase_finished_i,
    input wire logic interleave_set_i,
    input wire logic [7:0] last_confirm_opcode_i,
    input wire logic last_confirm_load_i,
    input wire logic [PLANES*2-1:0] fail_set_i,
    input wire logic [$clog2(PLANES)-1:0] selected_plane_index_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic irq_o,
    output logic internal_reset_o,
    output logic erase_start_o,
    output logic ready_o,
    output logic ready_report_o,
    output logic reset_complete_o,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic [7:0] unit_status_byte_o,
    output logic [7:0] last_status_opcode_o,
    output fus_pkg::fus_state_e state_o
);
    import fus_pkg::*;

    typedef struct packed {
        fus_state_e state;
        fus_state_e saved_return_state;
        logic [7:0] last_confirm_opcode;
        logic [7:0] last_status_opcode;
        logic [7:0] unit_status_byte;
        logic [PLANES*2-1:0] plane_fail_flags;
        logic [1:0] kind;
        logic interleave_active;
        logic internal_reset;
        logic erase_start;
        logic ready_report;
        logic reset_complete;
        logic [7:0] data;
        logic data_oe;
        logic [IRQ_WIDTH-1:0] irq_status;
        logic [IRQ_WIDTH-1:0] irq_mask;
        logic [31:0] rdata;
    } fus_regs_s;

    fus_regs_s r_q;
    fus_regs_s r_d;
    logic [7:0] composed;
    logic [IRQ_WIDTH-1:0] irq_event;

    // composed status byte for the current request kind
    fus_status_compose #(
        .PLANES(PLANES)
    ) u_compose (
        .unit_status_byte_i(r_q.unit_status_byte),
        .plane_fail_flags_i(r_q.plane_fail_flags),
        .selected_plane_index_i(selected_plane_index_i),
        .kind_i(r_q.kind),
        .status_o(composed)
    );

    function automatic logic is_read_confirm(input logic [7:0] op);
        return op == OP_READ_A || op == OP_READ_B || op == OP_READ_C ||
            op == OP_READ_D;
    endfunction : is_read_confirm

    // or of every plane's two fail bits, folded onto the unit fail bits
    function automatic logic [1:0] fail_fold(input logic [PLANES*2-1:0] f);
        logic [1:0] acc;
        acc = 2'h0;
        for (int p = 0; p < PLANES; p++) begin
            acc = acc | f[p*2 +: 2];
        end
        return acc;
    endfunction : fail_fold

    // next-state logic for the whole unit
    always_comb begin
        r_d = r_q;
        irq_event = '0;
        r_d.reset_complete = 1'b0;
        r_d.erase_start = 1'b0;
        r_d.ready_report = 1'b0;
        // target marks an interleaved operation; only reset clears it
        if (interleave_set_i) begin
            r_d.interleave_active = 1'b1;
        end
        if (last_confirm_load_i) begin
            r_d.last_confirm_opcode = last_confirm_opcode_i;
        end
        unique case (r_q.state)
            FUS_IDLE, FUS_IDLE_RD: begin
                if (status_req_i) begin
                    r_d.saved_return_state = r_q.state;
                    r_d.state = FUS_ST_EXEC;
                end else if (erase_confirm_i) begin
                    r_d.state = FUS_BE_CONFIRM;
                end
            end
            FUS_ST_EXEC: begin
                r_d.kind = status_kind_i;
                unique case (status_kind_i)
                    KIND_LEGACY: r_d.state = FUS_ST_LEGACY;
                    KIND_MPL_COMP: r_d.state = FUS_ST_COMP;
                    KIND_MPL_ADDR: r_d.state = FUS_ST_ADDR;
                    default: r_d.state = FUS_ST_UNIT;
                endcase
            end
            FUS_ST_LEGACY: begin
                r_d.last_status_opcode = OP_LEGACY_STATUS;
                r_d.kind = KIND_UNIT;
                r_d.state = FUS_ST_VALUE;
            end
            FUS_ST_UNIT, FUS_ST_COMP, FUS_ST_ADDR: begin
                r_d.state = FUS_ST_VALUE;
            end
            FUS_ST_VALUE: begin
                r_d.data = composed;
                r_d.data_oe = 1'b1;
                if (status_done_i) begin
                    irq_event[IRQ_STATUS_DONE] = 1'b1;
                    r_d.state = FUS_ST_OFF;
                end
            end
            FUS_ST_OFF: begin
                r_d.data_oe = 1'b0;
                if (r_q.saved_return_state == FUS_IDLE &&
                        is_read_confirm(r_q.last_confirm_opcode)) begin
                    r_d.state = FUS_IDLE_RD;
                end else if (r_q.saved_return_state == FUS_IDLE_RD) begin
                    r_d.state = FUS_IDLE;
                end else begin
                    r_d.state = r_q.saved_return_state;
                end
            end
            FUS_RST_RUN: begin
                if (reset_finished_i) begin
                    r_d.internal_reset = 1'b0;
                    r_d.state = FUS_RST_DONE;
                end else if (status_req_i) begin
                    r_d.state = FUS_ST_EXEC;
                end
            end
            FUS_RST_DONE: begin
                r_d.unit_status_byte[1:0] = 2'b00;
                r_d.plane_fail_flags = '0;
                r_d.unit_status_byte[BIT_READY] = 1'b1;
                r_d.ready_report = 1'b1;
                r_d.reset_complete = 1'b1;
                irq_event[IRQ_RESET_DONE] = 1'b1;
                r_d.state = FUS_IDLE;
            end
            FUS_BE_CONFIRM: begin
                r_d.unit_status_byte[BIT_READY] = 1'b0;
                if (r_q.interleave_active) begin
                    r_d.unit_status_byte[BIT_ARRAY_READY] = 1'b0;
                end
                r_d.ready_report = 1'b1;
                r_d.last_confirm_opcode = OP_ERASE_CONFIRM;
                r_d.erase_start = 1'b1;
                irq_event[IRQ_ERASE_START] = 1'b1;
                r_d.saved_return_state = FUS_BE_WAIT;
                r_d.state = FUS_BE_WAIT;
            end
            FUS_BE_WAIT: begin
                if (erase_finished_i) begin
                    r_d.unit_status_byte[BIT_READY] = 1'b1;
                    r_d.unit_status_byte[BIT_ARRAY_READY] = 1'b1;
                    r_d.ready_report = 1'b1;
                    r_d.state = FUS_IDLE;
                end else if (status_req_i) begin
                    r_d.state = FUS_ST_EXEC;
                end
            end
            default: r_d.state = FUS_IDLE;
        endcase
        // failures land after the case so a same-cycle clear loses
        r_d.plane_fail_flags = r_d.plane_fail_flags | fail_set_i;
        r_d.unit_status_byte[1:0] = r_d.unit_status_byte[1:0] |
            fail_fold(fail_set_i);
        // reset entry overrides every state
        if (reset_req_i) begin
            r_d.unit_status_byte[BIT_READY] = 1'b0;
            r_d.ready_report = 1'b1;
            r_d.internal_reset = 1'b1;
            r_d.interleave_active = 1'b0;
            r_d.saved_return_state = FUS_RST_RUN;
            r_d.data_oe = 1'b0;
            r_d.state = FUS_RST_RUN;
        end
        // register port: sticky status, write one to clear, set wins
        r_d.rdata = 32'h0;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_IRQ_STATUS: r_d.rdata = 32'(r_q.irq_status);
                REG_IRQ_MASK: r_d.rdata = 32'(r_q.irq_mask);
                REG_UNIT_STATE: r_d.rdata = {16'h0,
                    r_q.unit_status_byte, 4'h0, r_q.state};
                default: r_d.rdata = 32'h0;
            endcase
        end
        if (reg_wr_i && reg_addr_i == REG_IRQ_STATUS) begin
            r_d.irq_status = r_q.irq_status &
                ~reg_wdata_i[IRQ_WIDTH-1:0];
        end
        if (reg_wr_i && reg_addr_i == REG_IRQ_MASK) begin
            r_d.irq_mask = reg_wdata_i[IRQ_WIDTH-1:0];
        end
        r_d.irq_status = r_d.irq_status | irq_event;
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_q <= '{state: FUS_IDLE, saved_return_state: FUS_IDLE,
                last_confirm_opcode: OPCODE_RESET,
                last_status_opcode: OPCODE_RESET,
                unit_status_byte: STATUS_RESET, kind: KIND_UNIT,
                default: '0};
        end else if (ce_i) begin
            r_q <= r_d;
        end
    end

    // outputs straight from state flops, except irq_o, which is the or-reduce of irq status flops anded with mask flops
    assign reg_rdata_o = r_q.rdata;
    assign irq_o = |(r_q.irq_status & r_q.irq_mask);
    assign internal_reset_o = r_q.internal_reset;
    assign erase_start_o = r_q.erase_start;
    assign ready_o = r_q.unit_status_byte[BIT_READY];
    assign ready_report_o = r_q.ready_report;
    assign reset_complete_o = r_q.reset_complete;
    assign data_o = r_q.data;
    assign data_oe_o = r_q.data_oe;
    assign unit_status_byte_o = r_q.unit_status_byte;
    assign last_status_opcode_o = r_q.last_status_opcode;
    assign state_o = r_q.state;

    // sequencing checks; a frozen clock enable holds every antecedent off except that of a_oe_only_status
    a_reset_entry: assert property (@(posedge clk_i)
        disable iff (rst_i) ce_i && reset_req_i |=>
        state_o == FUS_RST_RUN && !ready_o)
        else $error("reset request did not enter reset-run");
    a_reset_done_idle: assert property (@(posedge clk_i)
        disable iff (rst_i) ce_i && state_o == FUS_RST_DONE &&
        !reset_req_i && !(|fail_set_i) |=> state_o == FUS_IDLE &&
        ready_o && reset_complete_o && unit_status_byte_o[1:0] == 2'b00)
        else $error("reset-done did not finish correctly");
    a_fail_clear: assert property (@(posedge clk_i)
        disable iff (rst_i) ce_i && state_o == FUS_RST_DONE &&
        !reset_req_i && !(|fail_set_i) |=> r_q.plane_fail_flags == '0)
        else $error("reset-done left plane fail flags set");
    a_run_exit: assert property (@(posedge clk_i)
        disable iff (rst_i) ce_i && state_o == FUS_RST_RUN &&
        reset_finished_i && !reset_req_i |=> state_o == FUS_RST_DONE)
        else $error("reset-run did not exit on completion");
    a_legacy_op: assert property (@(posedge clk_i)
        disable iff (rst_i) ce_i && state_o == FUS_ST_LEGACY &&
        !reset_req_i |=> last_status_opcode_o == OP_LEGACY_STATUS)
        else $error("legacy status opcode not recorded");
    a_erase_confirm: assert property (@(posedge clk_i)
        disable iff (rst_i) ce_i && state_o == FUS_BE_CONFIRM &&
        !reset_req_i |=> !ready_o && erase_start_o && ready_report_o)
        else $error("erase confirm did not drop ready");
    a_il_erase_bit5: assert property (@(posedge clk_i)
        disable iff (rst_i) ce_i && state_o == FUS_BE_CONFIRM &&
        r_q.interleave_active && !reset_req_i |=>
        !unit_status_byte_o[BIT_ARRAY_READY])
        else $error("interleaved erase kept array-ready bit");
    a_out_release: assert property (@(posedge clk_i)
        disable iff (rst_i) ce_i && state_o == FUS_ST_OFF |=> !data_oe_o)
        else $error("output not released after status");
    a_oe_only_status: assert property (@(posedge clk_i)
        disable iff (rst_i) data_oe_o |->
        state_o == FUS_ST_VALUE || state_o == FUS_ST_OFF)
        else $error("data driven outside status read");
    a_off_to_idle: assert property (@(posedge clk_i)
        disable iff (rst_i) ce_i && state_o == FUS_ST_OFF && !reset_req_i &&
        r_q.saved_return_state == FUS_IDLE_RD |=> state_o == FUS_IDLE)
        else $error("idle-read return not mapped to idle");
    a_read_return: assert property (@(posedge clk_i)
        disable iff (rst_i) ce_i && state_o == FUS_ST_OFF && !reset_req_i &&
        r_q.saved_return_state == FUS_IDLE &&
        is_read_confirm(r_q.last_confirm_opcode) |=> state_o == FUS_IDLE_RD)
        else $error("read confirm did not return to idle-read");
    a_rst_clear_il: assert property (@(posedge clk_i)
        disable iff (rst_i) ce_i && reset_req_i |=>
        !r_q.interleave_active && internal_reset_o)
        else $error("reset did not clear interleave");
endmodule : fus_unit_fsm

// ### fus_target_model.sv
// behavioural target-side model answering unit reset and erase work
`timescale 1ns/1ps
module fus_target_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] delay_i,
    input wire logic internal_reset_i,
    input wire logic erase_start_i,
    output logic reset_finished_o,
    output logic erase_finished_o
);
    logic [3:0] rcnt_q;
    logic [3:0] ecnt_q;
    logic rbusy_q;
    logic rdone_q;
    logic ebusy_q;
    // reset counts down while internal reset stands, one answer per request
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            {rcnt_q, ecnt_q, rbusy_q, rdone_q, ebusy_q} <= '0;
            {reset_finished_o, erase_finished_o} <= '0;
        end else begin
            reset_finished_o <= 1'h0;
            erase_finished_o <= 1'h0;
            if (!internal_reset_i) rdone_q <= 1'h0;
            if (internal_reset_i && !rbusy_q && !rdone_q) begin
                rbusy_q <= 1'h1;
                rcnt_q <= delay_i;
            end else if (internal_reset_i && rbusy_q) begin
                rcnt_q <= rcnt_q - 4'h1;
                if (rcnt_q == 4'h0) begin
                    reset_finished_o <= 1'h1;
                    rbusy_q <= 1'h0;
                    rdone_q <= 1'h1; // one answer per reset, not per cycle
                end
            end
            if (erase_start_i) begin
                ebusy_q <= 1'h1;
                ecnt_q <= delay_i;
            end else if (ebusy_q) begin
                ecnt_q <= ecnt_q - 4'h1;
                if (ecnt_q == 4'h0) begin
                    erase_finished_o <= 1'h1;
                    ebusy_q <= 1'h0;
                end
            end
        end
    end
endmodule : fus_target_model

// ### fus_tb.sv
// self-checking bench for the flash unit status and reset sequencer
`timescale 1ns/1ps
module testbench;
    import fus_pkg::*;
    logic clk_i, rst_i, ce_i, reset_req_i, reset_finished_i, status_req_i;
    logic status_done_i, erase_confirm_i, erase_finished_i, interleave_set_i;
    logic last_confirm_load_i, reg_wr_i, reg_rd_i, irq_o, internal_reset_o;
    logic erase_start_o, ready_o, ready_report_o, reset_complete_o, data_oe_o;
    logic [1:0] status_kind_i, selected_plane_index_i;
    logic [7:0] last_confirm_opcode_i, fail_set_i, data_o;
    logic [7:0] unit_status_byte_o, last_status_opcode_o;
    logic [3:0] reg_addr_i, delay_q;
    logic [31:0] reg_wdata_i, reg_rdata_o;
    fus_state_e state_o;
    int mismatches = 0;
    int tests_run = 0;

    fus_unit_fsm #(.PLANES(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .reset_req_i(reset_req_i), .reset_finished_i(reset_finished_i),
        .status_req_i(status_req_i), .status_kind_i(status_kind_i),
        .status_done_i(status_done_i), .erase_confirm_i(erase_confirm_i),
        .erase_finished_i(erase_finished_i),
        .interleave_set_i(interleave_set_i),
        .last_confirm_opcode_i(last_confirm_opcode_i),
        .last_confirm_load_i(last_confirm_load_i), .fail_set_i(fail_set_i),
        .selected_plane_index_i(selected_plane_index_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .irq_o(irq_o), .internal_reset_o(internal_reset_o),
        .erase_start_o(erase_start_o), .ready_o(ready_o),
        .ready_report_o(ready_report_o), .reset_complete_o(reset_complete_o),
        .data_o(data_o), .data_oe_o(data_oe_o),
        .unit_status_byte_o(unit_status_byte_o),
        .last_status_opcode_o(last_status_opcode_o), .state_o(state_o));

    fus_target_model target (.clk_i(clk_i), .rst_i(rst_i), .delay_i(delay_q),
        .internal_reset_i(internal_reset_o), .erase_start_i(erase_start_o),
        .reset_finished_o(reset_finished_i),
        .erase_finished_o(erase_finished_i));

    // 100 MHz clock
    always #5 clk_i = ~clk_i;

    task automatic give_verdict();
        if (mismatches == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    function automatic logic [31:0] probe(input int w);
        case (w)
            0: return {28'h0, state_o};
            1: return {31'h0, data_oe_o};
            2: return {31'h0, erase_start_o};
            default: return {31'h0, reset_complete_o};
        endcase
    endfunction : probe

    // bounded wait; running out ends the run as a failure
    task automatic wait_for(input int w, input logic [31:0] e);
        int n;
        for (n = 0; n < 40 && probe(w) !== e; n++) begin
            @(posedge clk_i);
            #1;
        end
        if (n == 40) begin
            mismatches++;
            $display("[FAIL] %0t wait timed out", $time);
            give_verdict();
        end
    endtask : wait_for

    // one-cycle strobe on a control input, taken at the second edge
    task automatic pulse(input int w);
        @(posedge clk_i);
        case (w)
            0: reset_req_i <= 1'h1;
            1: status_req_i <= 1'h1;
            2: status_done_i <= 1'h1;
            3: erase_confirm_i <= 1'h1;
            default: last_confirm_load_i <= 1'h1;
        endcase
        @(posedge clk_i);
        reset_req_i <= 1'h0;
        status_req_i <= 1'h0;
        status_done_i <= 1'h0;
        erase_confirm_i <= 1'h0;
        last_confirm_load_i <= 1'h0;
        #1;
    endtask : pulse

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'h1;
        @(posedge clk_i);
        reg_wr_i <= 1'h0;
        #1;
    endtask : reg_wr

    task automatic reg_chk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'h1;
        @(posedge clk_i);
        reg_rd_i <= 1'h0;
        #1;
        check(reg_rdata_o, e);
    endtask : reg_chk

    task automatic status_read(input logic [1:0] k, input logic [1:0] p,
                               input logic [7:0] e, input fus_state_e nxt);
        @(posedge clk_i);
        status_kind_i <= k;
        selected_plane_index_i <= p;
        pulse(1);
        wait_for(1, 32'h1);
        check({24'h0, data_o}, {24'h0, e});
        pulse(2);
        wait_for(0, {28'h0, nxt});
        check({31'h0, data_oe_o}, 32'h0);
    endtask : status_read

    task automatic do_reset(input logic [3:0] d, input bit detour);
        @(posedge clk_i);
        delay_q <= d;
        pulse(0);
        check({28'h0, state_o}, {28'h0, FUS_RST_RUN});
        check({30'h0, internal_reset_o, ready_o}, 32'h2);
        check({31'h0, data_oe_o}, 32'h0);
        if (detour) status_read(KIND_UNIT, 2'h0, 8'h03, FUS_RST_RUN);
        wait_for(3, 32'h1);
        check({28'h0, state_o}, {28'h0, FUS_IDLE});
        check({31'h0, ready_o}, 32'h1);
    endtask : do_reset

    task automatic regs_irq();
        reg_chk(REG_IRQ_STATUS, 32'h1);
        reg_chk(REG_UNIT_STATE, 32'h4000);
        reg_chk(4'hC, 32'h0);
        reg_wr(REG_IRQ_MASK, 32'h1);
        check({31'h0, irq_o}, 32'h1);
        reg_chk(REG_IRQ_MASK, 32'h1);
        reg_wr(REG_IRQ_STATUS, 32'h1);
        check({31'h0, irq_o}, 32'h0);
        reg_chk(REG_IRQ_STATUS, 32'h0);
    endtask : regs_irq

    task automatic status_kinds();
        @(posedge clk_i);
        fail_set_i <= 8'h24;
        @(posedge clk_i);
        fail_set_i <= 8'h00;
        status_read(KIND_MPL_COMP, 2'h0, 8'h43, FUS_IDLE);
        status_read(KIND_MPL_ADDR, 2'h1, 8'h41, FUS_IDLE);
        status_read(KIND_MPL_ADDR, 2'h2, 8'h42, FUS_IDLE);
        status_read(KIND_UNIT, 2'h0, 8'h43, FUS_IDLE);
        status_read(KIND_LEGACY, 2'h0, 8'h43, FUS_IDLE);
        check({24'h0, last_status_opcode_o}, 32'h70);
    endtask : status_kinds

    // clock enable low must freeze the unit in the middle of a read
    task automatic ce_freeze();
        @(posedge clk_i);
        status_kind_i <= KIND_UNIT;
        pulse(1);
        wait_for(1, 32'h1);
        ce_i <= 1'h0;
        pulse(2);
        check({27'h0, state_o, data_oe_o}, {27'h0, FUS_ST_VALUE, 1'b1});
        @(posedge clk_i);
        ce_i <= 1'h1;
        pulse(2);
        wait_for(0, {28'h0, FUS_IDLE});
        check({31'h0, data_oe_o}, 32'h0);
    endtask : ce_freeze

    // plain, interleaved, then post-reset erase: only the middle drops bit5
    task automatic erase_interleave();
        for (int i = 0; i < 3; i++) begin
            if (i == 2) do_reset(4'h2, 1'b0);
            @(posedge clk_i);
            interleave_set_i <= (i == 1);
            @(posedge clk_i);
            interleave_set_i <= 1'h0;
            pulse(3);
            wait_for(2, 32'h1);
            check({24'h0, unit_status_byte_o}, {26'h0, i != 1, 5'h0});
            wait_for(0, {28'h0, FUS_IDLE});
            check({24'h0, unit_status_byte_o}, 32'h60);
        end
    endtask : erase_interleave

    // reset lands mid-read, then fail flags must be gone
    task automatic reset_in_status();
        @(posedge clk_i);
        status_kind_i <= KIND_UNIT;
        pulse(1);
        wait_for(1, 32'h1);
        do_reset(4'hF, 1'b1);
        check({24'h0, unit_status_byte_o}, 32'h40);
        status_read(KIND_MPL_COMP, 2'h0, 8'h40, FUS_IDLE);
    endtask : reset_in_status

    task automatic erase_and_return();
        logic [7:0] ops [5] = '{8'h30, 8'h31, 8'h32, 8'h35, 8'h36};
        @(posedge clk_i);
        delay_q <= 4'h6;
        pulse(3);
        wait_for(2, 32'h1);
        check({30'h0, ready_o, ready_report_o}, 32'h1);
        wait_for(0, {28'h0, FUS_IDLE});
        status_read(KIND_UNIT, 2'h0, 8'h60, FUS_IDLE);
        reg_chk(REG_IRQ_STATUS, 32'h7);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_i);
            last_confirm_opcode_i <= ops[i];
            pulse(4);
            status_read(KIND_UNIT, 2'h0, 8'h60,
                        (i < 4) ? FUS_IDLE_RD : FUS_IDLE);
            if (i < 4) status_read(KIND_UNIT, 2'h0, 8'h60, FUS_IDLE);
        end
    endtask : erase_and_return

    // main sequence; clock enable stays on except while ce_freeze holds it low
    initial begin
        {clk_i, reset_req_i, status_req_i, status_done_i} = '0;
        {erase_confirm_i, last_confirm_load_i, reg_wr_i, reg_rd_i} = '0;
        {status_kind_i, selected_plane_index_i, fail_set_i} = '0;
        {last_confirm_opcode_i, reg_addr_i, reg_wdata_i, delay_q} = '0;
        interleave_set_i = 1'h0;
        ce_i = 1'h1;
        rst_i = 1'h1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        #1;
        check({29'h0, ready_o, data_oe_o, irq_o}, 32'h0);
        check({28'h0, state_o}, {28'h0, FUS_IDLE});
        do_reset(4'h0, 1'b0);
        regs_irq();
        status_kinds();
        ce_freeze();
        reset_in_status();
        erase_and_return();
        erase_interleave();
        give_verdict();
    end
endmodule : testbench
